// [eac_checker.sv]
/*
 Port checker for the link between the two controller ends.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "eac_params.svh"

// ==========
// Checker
module eac_checker #(
   parameter int ATOMIC_CYC = 40,
   parameter int SPLIT_CYC = 20
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic cpu_halt,
   input wire logic ready_irq
);
   localparam int T_LO = SPLIT_CYC;
   localparam int T_HI = ATOMIC_CYC + 6;
   logic ctl_wr;
   logic arm_wr;
   logic go_wr;
   logic [2:0] halt_cnt;

   // A control write is the only way to start anything on the device.
   assign ctl_wr = io_wr && io_addr == `EAC_OFS_CTRL;

   // Arm and go strobes as plain signals, so the launch checks can look one cycle back.
   assign arm_wr = ctl_wr && io_wdata[`EAC_B_ARM];
   assign go_wr = ctl_wr && io_wdata[`EAC_B_GO];

   // Counts the stall length; three bits still catch a stall of five.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         halt_cnt <= 3'h0;
      end else begin
         halt_cnt <= cpu_halt ? halt_cnt + 3'h1 : 3'h0;
      end
   end

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!NRST_I);

   a_read_halt_four: assert property (
      ctl_wr && io_wdata[`EAC_B_READ] |-> ##1 cpu_halt [*4] ##1 !cpu_halt)
      else $error("read stall is not four cycles");
   a_halt_at_most: assert property (halt_cnt <= 3'h4)
      else $error("stall longer than four cycles");
   a_launch_halt_two: assert property (
      go_wr && $past(arm_wr) |-> ##1 cpu_halt [*2] ##1 !cpu_halt)
      else $error("launch stall is not two cycles");
   a_busy_hides_ready: assert property (
      go_wr && $past(arm_wr) |-> ##2 !ready_irq [*8])
      else $error("ready shown while programming");
   a_ready_in_time: assert property (
      go_wr && $past(arm_wr) |-> ##[T_LO:T_HI] ready_irq)
      else $error("ready not back in time");
   a_rdata_quiet: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_ready_fall_cause: assert property (
      $fell(ready_irq) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
      else $error("ready fell with no control write");
   a_halt_blocks_io: assert property (cpu_halt |-> !io_wr && !io_rd)
      else $error("access issued during stall");
endmodule : eac_checker

// [eac_core.sv]
/*
 Processor-side end: takes one EEPROM command at a time from software through
 its own small register file and plays the register sequence on the device.
 Assumes the device end on the same clock and an asynchronous self-programming
 flag from outside.
*/
`timescale 1ns/1ps
`include "eac_params.svh"

module eac_core (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   output logic IRQ_O,
   input wire logic SELFPROG_ACTIVE_I,
   eac_if.core BUS_IO
);
   import eac_pkg::*;

   // ========================================================================
   // State
   // ========================================================================
   eac_host_t h_reg;
   eac_host_t h_next;
   logic [1:0] st_set;
   logic [1:0] st_clr;

   localparam eac_host_t HOST_RST = '{
      state: EAC_S_IDLE,
      op: EAC_M_ATOMIC,
      taddr: 8'h00,
      tdata: 8'h00,
      result: 8'h00,
      status: 2'h0,
      mask: 2'h0,
      irq: 1'b0,
      rdata: 8'h00,
      sp_s1: 1'b0,
      sp_s2: 1'b0,
      io_addr: 6'h00,
      io_wdata: 8'h00,
      io_wr: 1'b0,
      io_rd: 1'b0
   };

   // ========================================================================
   // Sequencer and register port
   // ========================================================================
   always_comb begin
      h_next = h_reg;
      h_next.io_wr = 1'b0;
      h_next.io_rd = 1'b0;
      h_next.rdata = 8'h00;
      h_next.sp_s1 = SELFPROG_ACTIVE_I;
      h_next.sp_s2 = h_reg.sp_s1;
      st_set = 2'h0;
      st_clr = 2'h0;

      case (h_reg.state)
         EAC_S_CHK: begin
            // Nothing is issued while the device stalls the core.
            if (!BUS_IO.cpu_halt) begin
               h_next.io_addr = `EAC_OFS_CTRL;
               h_next.io_rd = 1'b1;
               h_next.state = EAC_S_PW1;
            end
         end
         EAC_S_PW1: h_next.state = EAC_S_PEVAL;
         EAC_S_PEVAL: begin
            if (BUS_IO.io_rdata[`EAC_B_GO]) begin
               h_next.state = EAC_S_CHK;
            end else if ((h_reg.op != EAC_M_RSVD) && h_reg.sp_s2) begin
               h_next.state = EAC_S_CHK;
            end else if (h_reg.op == EAC_M_RSVD) begin
               h_next.state = EAC_S_ADDR;
            end else begin
               h_next.state = EAC_S_MODE;
            end
         end
         EAC_S_MODE: begin
            h_next.io_addr = `EAC_OFS_CTRL;
            h_next.io_wdata = {2'h0, h_reg.op, 4'h0};
            h_next.io_wr = 1'b1;
            h_next.state = EAC_S_ADDR;
         end
         EAC_S_ADDR: begin
            h_next.io_addr = `EAC_OFS_ADDR;
            h_next.io_wdata = h_reg.taddr;
            h_next.io_wr = 1'b1;
            if (h_reg.op == EAC_M_RSVD) begin
               h_next.state = EAC_S_RSTB;
            end else if (h_reg.op == EAC_M_ERASE) begin
               h_next.state = EAC_S_ARM;
            end else begin
               h_next.state = EAC_S_DATA;
            end
         end
         EAC_S_DATA: begin
            h_next.io_addr = `EAC_OFS_DATA;
            h_next.io_wdata = h_reg.tdata;
            h_next.io_wr = 1'b1;
            h_next.state = EAC_S_ARM;
         end
         EAC_S_ARM: begin
            h_next.io_addr = `EAC_OFS_CTRL;
            h_next.io_wdata = {2'h0, h_reg.op, 4'h4};
            h_next.io_wr = 1'b1;
            h_next.state = EAC_S_GO;
         end
         EAC_S_GO: begin
            // Go follows arm in the very next cycle, well inside the window.
            h_next.io_addr = `EAC_OFS_CTRL;
            h_next.io_wdata = {2'h0, h_reg.op, 4'hE};
            h_next.io_wr = 1'b1;
            h_next.state = EAC_S_WAITD;
         end
         EAC_S_WAITD: begin
            if (BUS_IO.ready_irq) begin
               st_set[`EAC_ST_DONE] = 1'b1;
               h_next.state = EAC_S_IDLE;
            end
         end
         EAC_S_RSTB: begin
            h_next.io_addr = `EAC_OFS_CTRL;
            h_next.io_wdata = 8'h01;
            h_next.io_wr = 1'b1;
            h_next.state = EAC_S_RHOLD;
         end
         EAC_S_RHOLD: h_next.state = EAC_S_RHALT;
         EAC_S_RHALT: begin
            if (!BUS_IO.cpu_halt) begin
               h_next.io_addr = `EAC_OFS_DATA;
               h_next.io_rd = 1'b1;
               h_next.state = EAC_S_RDW1;
            end
         end
         EAC_S_RDW1: h_next.state = EAC_S_RDV;
         EAC_S_RDV: begin
            h_next.result = BUS_IO.io_rdata;
            st_set[`EAC_ST_DONE] = 1'b1;
            h_next.state = EAC_S_IDLE;
         end
         default: h_next.state = h_reg.state;
      endcase

      // Software writes; a command while one runs is refused and flagged.
      if (WR_I) begin
         if (ADDR_I == `EAC_H_CMD) begin
            if (h_reg.state == EAC_S_IDLE) begin
               h_next.op = eac_method_t'(WDATA_I[1:0]);
               h_next.state = EAC_S_CHK;
            end else begin
               st_set[`EAC_ST_REJ] = 1'b1;
            end
         end else if (ADDR_I == `EAC_H_TADDR) begin
            h_next.taddr = WDATA_I;
         end else if (ADDR_I == `EAC_H_TDATA) begin
            h_next.tdata = WDATA_I;
         end else if (ADDR_I == `EAC_H_MASK) begin
            h_next.mask = WDATA_I[1:0];
         end
      end

      // Software reads; reading status clears it, unmapped reads give zero.
      if (RD_I) begin
         if (ADDR_I == `EAC_H_CMD) begin
            h_next.rdata = {h_reg.state != EAC_S_IDLE, 5'h00, h_reg.op};
         end else if (ADDR_I == `EAC_H_TADDR) begin
            h_next.rdata = h_reg.taddr;
         end else if (ADDR_I == `EAC_H_TDATA) begin
            h_next.rdata = h_reg.tdata;
         end else if (ADDR_I == `EAC_H_RESULT) begin
            h_next.rdata = h_reg.result;
         end else if (ADDR_I == `EAC_H_STATUS) begin
            h_next.rdata = {6'h00, h_reg.status};
            st_clr = 2'h3;
         end else if (ADDR_I == `EAC_H_MASK) begin
            h_next.rdata = {6'h00, h_reg.mask};
         end
      end

      // A new event in the clearing cycle survives the clear.
      h_next.status = (h_reg.status & ~st_clr) | st_set;
      h_next.irq = |(h_next.status & h_next.mask);
   end

   // ========================================================================
   // State register
   // ========================================================================
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         h_reg <= HOST_RST;
      end else begin
         h_reg <= h_next;
      end
   end

   // ========================================================================
   // Outputs
   // ========================================================================
   assign RDATA_O = h_reg.rdata;
   assign IRQ_O = h_reg.irq;
   assign BUS_IO.io_addr = h_reg.io_addr;
   assign BUS_IO.io_wdata = h_reg.io_wdata;
   assign BUS_IO.io_wr = h_reg.io_wr;
   assign BUS_IO.io_rd = h_reg.io_rd;

endmodule : eac_core

// [eac_dev.sv]
/*
 EEPROM device end: control, address and data registers, the arm-then-go
 unlock, the programming timer, the core stall and the ready request.
 Assumes one 10 MHz clock, a system reset NRST_I and a power-on reset NPOR_I
 that is asserted at least as long as NRST_I at power-up.
*/
`timescale 1ns/1ps
`include "eac_params.svh"

module eac_dev #(
   parameter int DEPTH = 256,
   parameter int unsigned ATOMIC_CYC = `EAC_T_ATOMIC_US * `EAC_CLK_KHZ / 1000,
   parameter int unsigned SPLIT_CYC = `EAC_T_SPLIT_US * `EAC_CLK_KHZ / 1000
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic NPOR_I,
   eac_if.dev BUS_IO,
   output logic BUSY_O
);
   import eac_pkg::*;

   // ========================================================================
   // State
   // ========================================================================
   eac_dreg_t r_reg;
   eac_dreg_t r_next;
   eac_eng_t e_reg;
   eac_eng_t e_next;
   logic [7:0] cell_mem [DEPTH];
   logic [7:0] cell_value;
   logic go_ok;

   // Reset image of the register file; address is unknown in the part, zero here.
   localparam eac_dreg_t DREG_RST = '{
      arm: 1'b0,
      arm_cnt: 3'h0,
      halt: 1'b0,
      halt_cnt: 3'h0,
      ien: 1'b0,
      method: eac_method_t'(`EAC_RST_METHOD),
      addr: `EAC_RST_ADDR,
      data: `EAC_RST_DATA,
      rdata: 8'h00,
      irq: 1'b0
   };

   localparam eac_eng_t ENG_RST = '{
      busy: 1'b0,
      method: EAC_M_ATOMIC,
      tgt_addr: 8'h00,
      tgt_data: 8'h00,
      timer: 16'h0000
   };

   // ========================================================================
   // Next-state logic for registers and engine
   // ========================================================================
   // A single process computes both images so the ready request can look at
   // the engine's next busy value and never shows a one-cycle glitch.
   always_comb begin
      r_next = r_reg;
      e_next = e_reg;
      r_next.rdata = 8'h00;
      go_ok = 1'b0;

      // The unlock window closes by itself after four cycles.
      if (r_reg.arm) begin
         if (r_reg.arm_cnt == 3'h0) begin
            r_next.arm = 1'b0;
         end else begin
            r_next.arm_cnt = r_reg.arm_cnt - 3'h1;
         end
      end

      // Core stall countdown shared by read and launch.
      if (r_reg.halt_cnt != 3'h0) begin
         r_next.halt_cnt = r_reg.halt_cnt - 3'h1;
      end

      // Programming timer; busy drops only when the full time has run.
      if (e_reg.busy) begin
         if (e_reg.timer == 16'h0000) begin
            e_next.busy = 1'b0;
         end else begin
            e_next.timer = e_reg.timer - 16'h0001;
         end
      end

      // Register writes from the core.
      if (BUS_IO.io_wr) begin
         if (BUS_IO.io_addr == `EAC_OFS_CTRL) begin
            r_next.ien = BUS_IO.io_wdata[`EAC_B_IEN];
            if (!e_reg.busy) begin
               r_next.method = eac_method_t'(BUS_IO.io_wdata[`EAC_B_METH_HI:`EAC_B_METH_LO]);
            end
            // Go counts only inside an open arm window, never while busy and
            // never for the reserved code.
            go_ok = BUS_IO.io_wdata[`EAC_B_GO] && r_reg.arm && !e_reg.busy
                    && (r_reg.method != EAC_M_RSVD);
            if (go_ok) begin
               e_next.busy = 1'b1;
               e_next.method = r_reg.method;
               e_next.tgt_addr = r_reg.addr;
               e_next.tgt_data = r_reg.data;
               if (r_reg.method == EAC_M_ATOMIC) begin
                  e_next.timer = 16'(ATOMIC_CYC - 1);
               end else begin
                  e_next.timer = 16'(SPLIT_CYC - 1);
               end
               r_next.arm = 1'b0;
               r_next.arm_cnt = 3'h0;
               r_next.halt_cnt = 3'(`EAC_PG_HALT_CYC);
            end else if (BUS_IO.io_wdata[`EAC_B_ARM]) begin
               r_next.arm = 1'b1;
               r_next.arm_cnt = 3'(`EAC_ARM_CYC - 1);
            end
            // A read strobe is refused outright while programming.
            if (BUS_IO.io_wdata[`EAC_B_READ] && !e_reg.busy && !go_ok) begin
               r_next.data = cell_mem[r_reg.addr];
               r_next.halt_cnt = 3'(`EAC_RD_HALT_CYC);
            end
         end else if (BUS_IO.io_addr == `EAC_OFS_DATA) begin
            r_next.data = BUS_IO.io_wdata;
         end else if (BUS_IO.io_addr == `EAC_OFS_ADDR) begin
            if (!e_reg.busy) begin
               r_next.addr = BUS_IO.io_wdata;
            end
         end
      end

      // Register reads; the answer stands one cycle and unmapped reads give zero.
      if (BUS_IO.io_rd) begin
         if (BUS_IO.io_addr == `EAC_OFS_CTRL) begin
            r_next.rdata = {2'h0, r_reg.method, r_reg.ien, r_reg.arm, e_reg.busy, 1'b0};
         end else if (BUS_IO.io_addr == `EAC_OFS_DATA) begin
            r_next.rdata = r_reg.data;
         end else if (BUS_IO.io_addr == `EAC_OFS_ADDR) begin
            r_next.rdata = r_reg.addr;
         end
      end

      r_next.halt = (r_next.halt_cnt != 3'h0);
      r_next.irq = r_next.ien && !e_next.busy;
   end

   // ========================================================================
   // Register file flops, cleared by the system reset
   // ========================================================================
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         r_reg <= DREG_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ========================================================================
   // Engine flops, cleared only at power-on
   // ========================================================================
   // The system reset is deliberately not wired here, so a running erase or
   // write finishes with its latched address, data and method.
   always_ff @(posedge CLK_I or negedge NPOR_I) begin
      if (!NPOR_I) begin
         e_reg <= ENG_RST;
      end else begin
         e_reg <= e_next;
      end
   end

   // ========================================================================
   // Cell array
   // ========================================================================
   // Erase sets all ones; programming can only clear bits, so a write-only
   // pass over an unerased byte leaves the AND of old and new contents.
   always_comb begin
      case (e_reg.method)
         EAC_M_ERASE: cell_value = 8'hFF;
         EAC_M_WRITE: cell_value = cell_mem[e_reg.tgt_addr] & e_reg.tgt_data;
         default: cell_value = e_reg.tgt_data;
      endcase
   end

   // The array has no reset: its contents are meant to outlive every reset.
   always_ff @(posedge CLK_I) begin
      if (e_reg.busy && (e_reg.timer == 16'h0000)) begin
         cell_mem[e_reg.tgt_addr] <= cell_value;
      end
   end

   // ========================================================================
   // Outputs
   // ========================================================================
   assign BUS_IO.io_rdata = r_reg.rdata;
   assign BUS_IO.cpu_halt = r_reg.halt;
   assign BUS_IO.ready_irq = r_reg.irq;
   assign BUSY_O = e_reg.busy;

endmodule : eac_dev

// [eac_if.sv]
/*
 Register port between the processor-side controller and the EEPROM device.
 Assumes both ends run on the same clock; no crossing is needed.
*/
`timescale 1ns/1ps

interface eac_if;
   logic [5:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic cpu_halt;
   logic ready_irq;

   modport dev (
      input io_addr,
      input io_wdata,
      input io_wr,
      input io_rd,
      output io_rdata,
      output cpu_halt,
      output ready_irq
   );

   modport core (
      output io_addr,
      output io_wdata,
      output io_wr,
      output io_rd,
      input io_rdata,
      input cpu_halt,
      input ready_irq
   );
endinterface : eac_if

// [eac_params.svh]
/*
 Constants of the EEPROM access controller: I/O offsets, bit positions,
 reset values and timing figures of the device end, and the register map of
 the controller end. Assumes it is included by every design file by bare name.
*/
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define EAC_CLK_KHZ 10000
`define EAC_T_ATOMIC_US 3400
`define EAC_T_SPLIT_US 1800
`define EAC_ARM_CYC 4
`define EAC_RD_HALT_CYC 4
`define EAC_PG_HALT_CYC 2

// ==========================================================================
// Device I/O map and control bit positions
// ==========================================================================
`define EAC_OFS_CTRL 6'h1F
`define EAC_OFS_DATA 6'h20
`define EAC_OFS_ADDR 6'h21
`define EAC_B_READ 0
`define EAC_B_GO 1
`define EAC_B_ARM 2
`define EAC_B_IEN 3
`define EAC_B_METH_LO 4
`define EAC_B_METH_HI 5
`define EAC_RST_METHOD 2'h0
`define EAC_RST_DATA 8'h00
`define EAC_RST_ADDR 8'h00

// ==========================================================================
// Controller register map
// ==========================================================================
`define EAC_H_CMD 3'h0
`define EAC_H_TADDR 3'h1
`define EAC_H_TDATA 3'h2
`define EAC_H_RESULT 3'h3
`define EAC_H_STATUS 3'h4
`define EAC_H_MASK 3'h5
`define EAC_ST_DONE 0
`define EAC_ST_REJ 1

`endif

// [eac_pkg.sv]
/*
 Types shared by both ends of the EEPROM access controller.
 Assumes eac_params.svh is on the include path.
*/
package eac_pkg;

   // =======================================================================
   // Programming methods; the controller reuses code 3 for a read.
   // =======================================================================
   typedef enum logic [1:0] {
      EAC_M_ATOMIC = 2'h0,
      EAC_M_ERASE = 2'h1,
      EAC_M_WRITE = 2'h2,
      EAC_M_RSVD = 2'h3
   } eac_method_t;

   // =======================================================================
   // Device state: register file and programming engine.
   // =======================================================================
   typedef struct packed {
      logic arm;
      logic [2:0] arm_cnt;
      logic halt;
      logic [2:0] halt_cnt;
      logic ien;
      eac_method_t method;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] rdata;
      logic irq;
   } eac_dreg_t;

   typedef struct packed {
      logic busy;
      eac_method_t method;
      logic [7:0] tgt_addr;
      logic [7:0] tgt_data;
      logic [15:0] timer;
   } eac_eng_t;

   // =======================================================================
   // Controller sequencer states, Gray coded along the programming path.
   // =======================================================================
   typedef enum logic [3:0] {
      EAC_S_IDLE = 4'h0,
      EAC_S_CHK = 4'h1,
      EAC_S_PW1 = 4'h3,
      EAC_S_PEVAL = 4'h2,
      EAC_S_MODE = 4'h6,
      EAC_S_ADDR = 4'h7,
      EAC_S_DATA = 4'h5,
      EAC_S_ARM = 4'h4,
      EAC_S_GO = 4'hC,
      EAC_S_WAITD = 4'hD,
      EAC_S_RSTB = 4'hF,
      EAC_S_RHOLD = 4'hE,
      EAC_S_RHALT = 4'hA,
      EAC_S_RDW1 = 4'hB,
      EAC_S_RDV = 4'h9
   } eac_state_t;

   typedef struct packed {
      eac_state_t state;
      eac_method_t op;
      logic [7:0] taddr;
      logic [7:0] tdata;
      logic [7:0] result;
      logic [1:0] status;
      logic [1:0] mask;
      logic irq;
      logic [7:0] rdata;
      logic sp_s1;
      logic sp_s2;
      logic [5:0] io_addr;
      logic [7:0] io_wdata;
      logic io_wr;
      logic io_rd;
   } eac_host_t;

endpackage : eac_pkg

// [test_eeprom_access_controller.sv]
/*
 Bench for both ends of the controller joined by their interface.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "eac_params.svh"

module test_eeprom_access_controller;
   typedef struct packed {
      logic [1:0] op;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] n;
      logic [7:0] q;
   } eac_row_t;
   localparam int AT = 40;
   localparam int SP = 20;
   // Erase gives FF; a write-only over a written byte keeps old AND new.
   localparam eac_row_t ROWS [6] = '{
      '{2'h1, 8'h05, 8'h00, 8'(SP), 8'hFF},
      '{2'h2, 8'h05, 8'h5A, 8'(SP), 8'h5A},
      '{2'h0, 8'h05, 8'hA5, 8'(AT), 8'hA5},
      '{2'h2, 8'h05, 8'h0F, 8'(SP), 8'h05},
      '{2'h0, 8'hFF, 8'h3C, 8'(AT), 8'h3C},
      '{2'h1, 8'h00, 8'h00, 8'(SP), 8'hFF}};
   logic clk = 1'b0;
   logic nrst_n = 1'b0;
   logic npor_n = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic sp = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] v;
   logic irq;
   logic busy;
   int busy_cnt = 0;
   int n_errors = 0;
   int comparisons = 0;

   eac_if u_eac_if();
   eac_dev #(.ATOMIC_CYC(AT), .SPLIT_CYC(SP)) u_eac_dev (.CLK_I(clk), .NRST_I(nrst_n),
      .NPOR_I(npor_n), .BUS_IO(u_eac_if.dev), .BUSY_O(busy));
   eac_core u_eac_core (.CLK_I(clk), .NRST_I(nrst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq),
      .SELFPROG_ACTIVE_I(sp), .BUS_IO(u_eac_if.core));
   eac_checker #(.ATOMIC_CYC(AT), .SPLIT_CYC(SP)) u_eac_checker (.CLK_I(clk),
      .NRST_I(nrst_n), .io_addr(u_eac_if.io_addr), .io_wdata(u_eac_if.io_wdata),
      .io_wr(u_eac_if.io_wr), .io_rd(u_eac_if.io_rd), .io_rdata(u_eac_if.io_rdata),
      .cpu_halt(u_eac_if.cpu_halt), .ready_irq(u_eac_if.ready_irq));

   // ==========
   // Clock and busy counter, sampled away from the active edge.
   always #50 clk = ~clk;
   always @(negedge clk) begin
      if (busy === 1'b1) busy_cnt++;
   end

   // ==========
   // Register port tasks; each leaves a free edge so strobes never clash.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      // The answer stands one cycle only; take it mid-cycle, clear of the edge.
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : rd

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_irq();
      int i;
      for (i = 0; i < 200; i++) begin
         @(negedge clk);
         if (irq === 1'b1) break;
      end
      if (i == 200) begin
         n_errors++;
         $display("BAD %0t no completion", $time);
         complete_run();
      end
      @(posedge clk);
   endtask : wait_irq

   task automatic do_op(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
      wr(`EAC_H_TADDR, a);
      wr(`EAC_H_TDATA, d);
      wr(`EAC_H_CMD, {6'h00, op});
      wait_irq();
      rd(`EAC_H_STATUS, v);
      chk(v, 8'h01);
   endtask : do_op

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   // ==========
   // Main sequence: reset values first, then the table rows, then the awkward cases.
   initial begin
      repeat (5) @(posedge clk);
      nrst_n <= 1'b1;
      npor_n <= 1'b1;
      @(posedge clk);
      rd(`EAC_H_STATUS, v);
      chk(v, 8'h00);
      rd(3'h7, v);
      chk(v, 8'h00);
      chk({7'h00, irq}, 8'h00);
      $display("reset values done");
      wr(`EAC_H_MASK, 8'h03);
      rd(`EAC_H_MASK, v);
      chk(v, 8'h03);
      foreach (ROWS[i]) begin
         busy_cnt = 0;
         do_op(ROWS[i].op, ROWS[i].a, ROWS[i].d);
         chk(busy_cnt[7:0], ROWS[i].n);
         do_op(2'h3, ROWS[i].a, 8'h00);
         rd(`EAC_H_RESULT, v);
         chk(v, ROWS[i].q);
      end
      $display("table rows done");
      wr(`EAC_H_MASK, 8'h00);
      wr(`EAC_H_CMD, 8'h03);
      repeat (30) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      rd(`EAC_H_STATUS, v);
      chk(v, 8'h01);
      $display("masked done");
      wr(`EAC_H_MASK, 8'h03);
      wr(`EAC_H_TADDR, 8'h10);
      wr(`EAC_H_TDATA, 8'h77);
      busy_cnt = 0;
      wr(`EAC_H_CMD, 8'h00);
      repeat (15) @(posedge clk);
      rd(`EAC_H_CMD, v);
      chk(v, 8'h80);
      wr(`EAC_H_CMD, 8'h03);
      rd(`EAC_H_STATUS, v);
      chk(v, 8'h02);
      nrst_n <= 1'b0;
      @(posedge clk);
      nrst_n <= 1'b1;
      @(posedge clk);
      chk({7'h00, busy}, 8'h01);
      wr(`EAC_H_MASK, 8'h01);
      do_op(2'h3, 8'h10, 8'h00);
      chk(busy_cnt[7:0], 8'(AT));
      rd(`EAC_H_RESULT, v);
      chk(v, 8'h77);
      $display("reset in flight done");
      sp <= 1'b1;
      busy_cnt = 0;
      wr(`EAC_H_TADDR, 8'h20);
      wr(`EAC_H_CMD, 8'h01);
      repeat (30) @(posedge clk);
      chk({7'h00, busy}, 8'h00);
      sp <= 1'b0;
      wait_irq();
      chk(busy_cnt[7:0], 8'(SP));
      $display("self-programming wait done");
      complete_run();
   end
endmodule : test_eeprom_access_controller
